// [rtl/tca_pkg.sv]
/*
  tca_pkg: shared constants and types for the transmit command and
  receive address filter block.
  assumes: a 250 MHz core clock and a 10 Mb/s serial line.
*/
package tca_pkg;

  // byte offsets on the 16-bit register port
  localparam logic [9:0] OFF_TXCFG = 10'h108;
  localparam logic [9:0] OFF_CMD   = 10'h144;
  localparam logic [9:0] OFF_LEN   = 10'h146;
  localparam logic [9:0] OFF_MHF   = 10'h150;
  localparam logic [9:0] OFF_STA   = 10'h158;
  localparam int         MHF_WORDS = 4;
  localparam int         STA_WORDS = 3;

  // command word fields
  localparam logic [5:0] CMD_ID      = 6'h09;
  localparam int         ID_W        = 6;
  localparam int         TH_LSB      = 6;
  localparam int         ABORT_BIT   = 8;
  localparam int         ONECOLL_BIT = 9;
  localparam int         FCSOFF_BIT  = 12;
  localparam int         PADOFF_BIT  = 13;

  // start thresholds in buffered bytes
  localparam logic [10:0] TH_SEL0 = 11'h005;
  localparam logic [10:0] TH_SEL1 = 11'h17d;
  localparam logic [10:0] TH_SEL2 = 11'h3fd;

  localparam logic [15:0] MIN_LEN  = 16'h0003;
  localparam logic [15:0] PAD_LEN  = 16'h003c;
  localparam logic [4:0]  MAX_COLL = 5'h10;

  // abort must end the frame within this many bit times
  localparam int KILL_BITS   = 64;
  localparam int BIT_NS      = 100;
  localparam int CLK_NS      = 4;
  localparam int KILL_CYC    = KILL_BITS * BIT_NS / CLK_NS;
  localparam logic [10:0] KILL_CNT = 11'(KILL_CYC);

  // ethernet crc
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  typedef enum logic [1:0] {
    TCA_IDLE,
    TCA_FILL,
    TCA_SEND
  } tca_state_t;

endpackage

// [rtl/tca_hash_if.sv]
/*
  tca_hash_if: carries a received destination address to the hash
  decoder and its six-bit index back.
  assumes: both ends run on the same clock.
*/
`timescale 1ns/1ns
interface tca_hash_if;
  logic [47:0] da;
  logic        da_valid;
  logic [5:0]  idx;
  logic        idx_valid;
  logic        mcast;

  modport ctrl   (output da, output da_valid,
                  input idx, input idx_valid, input mcast);
  modport hasher (input da, input da_valid,
                  output idx, output idx_valid, output mcast);
endinterface

// [rtl/tca_hash.sv]
/*
  tca_hash: crc based hash decoder for destination addresses.
  assumes: an address arrives with octet 0 in bits 7:0, first bit lsb.
*/
`timescale 1ns/1ns
module tca_hash (
  input  wire logic      clock,
  input  wire logic      rst,
  tca_hash_if.hasher     hif
);

  typedef struct packed {
    logic [5:0] idx;
    logic       idx_valid;
    logic       mcast;
  } tca_hash_st_t;

  tca_hash_st_t s_r;
  tca_hash_st_t s_nxt;

  // crc over the address in wire order; the top six bits give the index
  function automatic logic [5:0] crc_index(input logic [47:0] a);
    logic [31:0] c;
    c = tca_pkg::CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      if (c[31] ^ a[i]) begin
        c = {c[30:0], 1'b0} ^ tca_pkg::CRC_POLY;
      end else begin
        c = {c[30:0], 1'b0};
      end
    end
    crc_index = c[31:26];
  endfunction

  always_comb begin
    s_nxt           = s_r;
    s_nxt.idx_valid = hif.da_valid;
    if (hif.da_valid) begin
      s_nxt.idx   = crc_index(hif.da);
      s_nxt.mcast = hif.da[0];
    end
    if (rst) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    s_r <= s_nxt;
  end

  assign hif.idx       = s_r.idx;
  assign hif.idx_valid = s_r.idx_valid;
  assign hif.mcast     = s_r.mcast;

endmodule // tca_hash

// [rtl/tca_top.sv]
/*
  tca_top: transmit command, transmit length and receive address filter
  registers, with the transmit start, abort and collision control.
  assumes: a 16-bit register port with byte lanes, one access per
  cycle; a transmit engine that reports buffered bytes, collisions and
  frame end; a receive path that presents each destination address once.
*/
`timescale 1ns/1ns
module tca_top (
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic [9:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic [1:0]  reg_be,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  // transmit engine
  input  wire logic [10:0] tx_buf_count,
  input  wire logic        tx_frame_whole,
  input  wire logic        tx_collision,
  input  wire logic        tx_done,
  output logic             tx_start,
  output logic             tx_refuse,
  output logic             tx_flush,
  output logic             tx_kill,
  output logic             tx_abandon,
  output logic             tx_retry,
  output logic             tx_append_fcs,
  output logic             tx_pad_60,
  output logic [15:0]      tx_length,
  // station address load from configuration storage
  input  wire logic        cfg_addr_valid,
  input  wire logic [47:0] cfg_addr,
  // receive address filter
  input  wire logic [47:0] rx_da,
  input  wire logic        rx_da_valid,
  output logic             rx_hashed,
  output logic             rx_station_match,
  output logic [47:0]      station_address
);

  //////////////////////////////////////////////////////////////////////
  typedef struct packed {
    tca_pkg::tca_state_t state;
    logic [15:0] cmd;
    logic [15:0] len;
    logic        armed;
    logic [63:0] mhf;
    logic [47:0] sta;
    logic [47:0] da;
    logic [15:0] rdata;
    logic        rvalid;
    logic [4:0]  coll;
    logic [10:0] kill_cnt;
    logic        start;
    logic        refuse;
    logic        flush;
    logic        kill;
    logic        abandon;
    logic        retry;
    logic        fcs;
    logic        pad;
    logic        hashed;
    logic        smatch;
  } tca_st_t;

  tca_st_t s_r;
  tca_st_t s_nxt;

  tca_hash_if hif ();

  tca_hash u_hash (
    .clock (clock),
    .rst   (rst),
    .hif   (hif)
  );

  assign hif.da       = rx_da;
  assign hif.da_valid = rx_da_valid;

  //////////////////////////////////////////////////////////////////////
  // byte-lane merge, shared by every writable word
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic [10:0] threshold(input logic [1:0] sel);
    unique case (sel)
      2'b00:   threshold = tca_pkg::TH_SEL0;
      2'b01:   threshold = tca_pkg::TH_SEL1;
      default: threshold = tca_pkg::TH_SEL2;
    endcase
  endfunction

  logic [8:0] wa;
  logic       hit_cmd;
  logic       hit_len;
  logic       hit_mhf;
  logic       hit_sta;
  logic [1:0] mhf_w;
  logic [1:0] sta_w;
  logic       go;

  assign wa      = reg_addr[9:1];
  assign hit_cmd = wa == tca_pkg::OFF_CMD[9:1];
  assign hit_len = wa == tca_pkg::OFF_LEN[9:1];
  assign hit_mhf = wa >= tca_pkg::OFF_MHF[9:1] &&
                   wa <  tca_pkg::OFF_MHF[9:1] + 9'(tca_pkg::MHF_WORDS);
  assign hit_sta = wa >= tca_pkg::OFF_STA[9:1] &&
                   wa <  tca_pkg::OFF_STA[9:1] + 9'(tca_pkg::STA_WORDS);
  assign mhf_w   = 2'(wa - tca_pkg::OFF_MHF[9:1]);
  assign sta_w   = 2'(wa - tca_pkg::OFF_STA[9:1]);

  // select 11 waits for the whole frame; the others start at their threshold or once the whole frame is in the buffer
  assign go = s_r.cmd[tca_pkg::TH_LSB +: 2] == 2'b11 ? tx_frame_whole :
              (tx_buf_count >= threshold(s_r.cmd[tca_pkg::TH_LSB +: 2]) ||
               tx_frame_whole);

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt         = s_r;
    s_nxt.start   = 1'b0;
    s_nxt.refuse  = 1'b0;
    s_nxt.flush   = 1'b0;
    s_nxt.abandon = 1'b0;
    s_nxt.retry   = 1'b0;
    s_nxt.hashed  = 1'b0;
    s_nxt.smatch  = 1'b0;
    s_nxt.rvalid  = reg_rd;

    // storage load first so that a software write in the same cycle wins
    if (cfg_addr_valid) begin
      s_nxt.sta = cfg_addr;
    end

    if (reg_wr) begin
      if (hit_cmd) begin
        s_nxt.cmd   = merge16(s_r.cmd, reg_wdata, reg_be);
        s_nxt.armed = 1'b1;
        if (reg_be[1] && reg_wdata[tca_pkg::ABORT_BIT]) begin
          s_nxt.flush = 1'b1;
          if (s_r.state == tca_pkg::TCA_SEND && !s_r.kill) begin
            s_nxt.kill     = 1'b1;
            s_nxt.kill_cnt = tca_pkg::KILL_CNT;
          end
          if (s_r.state == tca_pkg::TCA_FILL) begin
            s_nxt.state = tca_pkg::TCA_IDLE;
          end
        end
      end
      if (hit_len) begin
        s_nxt.len = merge16(s_r.len, reg_wdata, reg_be);
        // the high byte completes the request
        if (reg_be[1] && s_r.armed) begin
          s_nxt.armed = 1'b0;
          if (s_nxt.len < tca_pkg::MIN_LEN) begin
            s_nxt.refuse = 1'b1;
          end else if (s_r.state == tca_pkg::TCA_IDLE) begin
            s_nxt.state = tca_pkg::TCA_FILL;
          end
        end
      end
      if (hit_mhf) begin
        s_nxt.mhf[16*mhf_w +: 16] =
          merge16(s_r.mhf[16*mhf_w +: 16], reg_wdata, reg_be);
      end
      if (hit_sta) begin
        s_nxt.sta[16*sta_w +: 16] =
          merge16(s_r.sta[16*sta_w +: 16], reg_wdata, reg_be);
      end
    end

    // write-only locations and unmapped words read as zero
    if (reg_rd) begin
      s_nxt.rdata = 16'h0000;
      if (wa == tca_pkg::OFF_TXCFG[9:1]) begin
        s_nxt.rdata = {s_r.cmd[15:tca_pkg::ID_W], tca_pkg::CMD_ID};
      end else if (hit_mhf) begin
        s_nxt.rdata = s_r.mhf[16*mhf_w +: 16];
      end else if (hit_sta) begin
        s_nxt.rdata = s_r.sta[16*sta_w +: 16];
      end
    end

    unique case (s_r.state)
      tca_pkg::TCA_IDLE: begin
        s_nxt.coll = 5'h00;
      end
      tca_pkg::TCA_FILL: begin
        if (go && s_nxt.state == tca_pkg::TCA_FILL) begin
          s_nxt.state = tca_pkg::TCA_SEND;
          s_nxt.start = 1'b1;
          s_nxt.fcs   = !s_r.cmd[tca_pkg::FCSOFF_BIT];
          s_nxt.pad   = !s_r.cmd[tca_pkg::PADOFF_BIT] &&
                        s_r.len < tca_pkg::PAD_LEN;
        end
      end
      tca_pkg::TCA_SEND: begin
        if (s_r.kill) begin
          // the engine is told to stop; the deadline forces the end
          s_nxt.kill_cnt = s_r.kill_cnt - 11'h001;
          if (tx_done || s_r.kill_cnt == 11'h001) begin
            s_nxt.kill  = 1'b0;
            s_nxt.state = tca_pkg::TCA_IDLE;
          end
        end else if (tx_done) begin
          s_nxt.state = tca_pkg::TCA_IDLE;
        end else if (tx_collision) begin
          s_nxt.coll = s_r.coll + 5'h01;
          if (s_r.cmd[tca_pkg::ONECOLL_BIT] ||
              s_nxt.coll == tca_pkg::MAX_COLL) begin
            s_nxt.abandon = 1'b1;
            s_nxt.state   = tca_pkg::TCA_IDLE;
          end else begin
            s_nxt.retry = 1'b1;
          end
        end
      end
    endcase

    // receive filter: hash only multicast, compare every address to station
    if (hif.idx_valid) begin
      s_nxt.hashed = hif.mcast && s_r.mhf[hif.idx];
      s_nxt.smatch = s_r.da == s_r.sta;
    end
    if (rx_da_valid) begin
      s_nxt.da = rx_da;
    end

    // command and length are cleared too: harmless, keeps outputs known
    if (rst) begin
      s_nxt       = '0;
      s_nxt.state = tca_pkg::TCA_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  assign reg_rdata        = s_r.rdata;
  assign reg_rvalid       = s_r.rvalid;
  assign tx_start         = s_r.start;
  assign tx_refuse        = s_r.refuse;
  assign tx_flush         = s_r.flush;
  assign tx_kill          = s_r.kill;
  assign tx_abandon       = s_r.abandon;
  assign tx_retry         = s_r.retry;
  assign tx_append_fcs    = s_r.fcs;
  assign tx_pad_60        = s_r.pad;
  assign tx_length        = s_r.len;
  assign rx_hashed        = s_r.hashed;
  assign rx_station_match = s_r.smatch;
  assign station_address  = s_r.sta;

  //////////////////////////////////////////////////////////////////////
  a_id_readback:
    assert property (@(posedge clock) disable iff (rst)
      reg_rd && reg_addr == tca_pkg::OFF_TXCFG
      |=> reg_rvalid && reg_rdata[5:0] == 6'b001001)
    else $error("command readback id bits wrong");

  a_cmd_readback:
    assert property (@(posedge clock) disable iff (rst)
      reg_wr && reg_addr == tca_pkg::OFF_CMD && reg_be == 2'b11
      ##1 !reg_wr
      ##1 reg_rd && reg_addr == tca_pkg::OFF_TXCFG && !reg_wr
      |=> reg_rdata[15:6] == $past(reg_wdata[15:6], 3))
    else $error("command word not read back");

  a_short_refused:
    assert property (@(posedge clock) disable iff (rst)
      reg_wr && reg_addr == tca_pkg::OFF_LEN && reg_be == 2'b11 &&
      s_r.armed && reg_wdata < 16'h0003
      |=> tx_refuse && !tx_start)
    else $error("short frame not refused");

  a_thresh_start:
    assert property (@(posedge clock) disable iff (rst)
      s_r.state == tca_pkg::TCA_FILL && !reg_wr &&
      s_r.cmd[7:6] == 2'b00 && tx_buf_count >= 11'h005
      |=> tx_start ##1 !tx_start)
    else $error("transmit did not start at five bytes");

  a_whole_only:
    assert property (@(posedge clock) disable iff (rst)
      s_r.state == tca_pkg::TCA_FILL && s_r.cmd[7:6] == 2'b11 &&
      !tx_frame_whole |=> !tx_start)
    else $error("started before whole frame buffered");

  a_force_flush:
    assert property (@(posedge clock) disable iff (rst)
      reg_wr && reg_addr == tca_pkg::OFF_CMD && reg_be[1] && reg_wdata[8]
      |=> tx_flush)
    else $error("abort command did not flush");

  a_kill_deadline:
    assert property (@(posedge clock) disable iff (rst)
      tx_kill && s_r.kill_cnt == 11'h001 |=> !tx_kill)
    else $error("aborted frame outlived its deadline");

  a_one_coll:
    assert property (@(posedge clock) disable iff (rst)
      s_r.state == tca_pkg::TCA_SEND && !tx_kill && !tx_done &&
      tx_collision && s_r.cmd[9]
      |=> tx_abandon && !tx_retry)
    else $error("single collision mode did not abandon");

  a_sixteen_coll:
    assert property (@(posedge clock) disable iff (rst)
      s_r.state == tca_pkg::TCA_SEND && !tx_kill && !tx_done &&
      tx_collision && !s_r.cmd[9]
      |=> (tx_abandon == ($past(s_r.coll) == 5'h0f)) &&
          (tx_retry == ($past(s_r.coll) != 5'h0f)))
    else $error("collision limit not sixteen");

  a_fcs_pad:
    assert property (@(posedge clock) disable iff (rst)
      tx_start |-> tx_append_fcs == !s_r.cmd[12] &&
                   tx_pad_60 == (!s_r.cmd[13] && s_r.len < 16'h003c))
    else $error("crc or pad setting wrong at start");

  a_hash_flag:
    assert property (@(posedge clock) disable iff (rst)
      hif.idx_valid |=> rx_hashed == $past(hif.mcast && s_r.mhf[hif.idx]))
    else $error("hash flag disagrees with filter bit");

  a_filter_reset:
    assert property (@(posedge clock)
      $past(rst) |-> s_r.mhf == 64'h0 && !tx_start)
    else $error("hash filter not cleared by reset");

endmodule // tca_top

// [tb/tca_eng_model.sv]
/*
  tca_eng_model: transmit engine beside the block; fills the buffer,
  sends, collides and ends frames.
  assumes: the block's clock; the bench sets fill level and collisions.
*/
`timescale 1ns/1ns
module tca_eng_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [10:0] fill,
  input  wire logic        whole_in,
  input  wire logic [4:0]  n_coll,
  input  wire logic        tx_start,
  input  wire logic        tx_kill,
  input  wire logic        tx_abandon,
  input  wire logic        kill_deaf,
  output logic      [10:0] tx_buf_count,
  output logic             tx_frame_whole,
  output logic             tx_collision,
  output logic             tx_done
);
  logic       busy;
  logic [4:0] seen;
  int         t;

  assign tx_frame_whole = whole_in;

  always @(posedge clock) begin
    tx_collision <= 1'b0;
    tx_done      <= 1'b0;
    if (rst) begin
      tx_buf_count <= 11'h000;
      busy         <= 1'b0;
    end else begin
      // bytes trickle in one per cycle so every count is seen
      if (tx_buf_count < fill)
        tx_buf_count <= tx_buf_count + 11'h001;
      else
        tx_buf_count <= fill;
      if (tx_start) begin
        busy <= 1'b1;
        seen <= 5'h00;
        t    <= 0;
      end else if (busy) begin
        t <= t + 1;
        // a deaf engine never ends on its own, so only the deadline can
        if (tx_abandon || (!kill_deaf && ((tx_kill && t >= 10) ||
            (seen == n_coll && t == 20)))) begin
          busy    <= 1'b0;
          tx_done <= 1'b1;
        end else if (t == 8 && seen < n_coll && !tx_kill) begin
          tx_collision <= 1'b1;
          seen         <= seen + 5'h01;
          t            <= 0;
        end
      end
    end
  end
endmodule // tca_eng_model

// [tb/tx_command_and_address_filter_test.sv]
/*
  tx_command_and_address_filter_test: register, transmit and filter
  scenarios for tca_top.
  assumes: inputs move 1 ns after the rising edge.
*/
`timescale 1ns/1ns
module tx_command_and_address_filter_test;
  logic        clock, rst, reg_wr, reg_rd, reg_rvalid;
  logic [9:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, tx_length;
  logic [1:0]  reg_be;
  logic [10:0] tx_buf_count, fill;
  logic [4:0]  n_coll;
  logic        whole_in, tx_frame_whole, tx_collision, tx_done;
  logic        kill_deaf;
  logic        tx_start, tx_refuse, tx_flush, tx_kill, tx_abandon;
  logic        tx_retry, tx_append_fcs, tx_pad_60;
  logic        cfg_addr_valid, rx_da_valid, rx_hashed, rx_station_match;
  logic [47:0] cfg_addr, rx_da, station_address;
  int          err_count, checks_done, i, k;
  int          n_start, n_ref, n_flush, n_retry, n_aband, n_hash;
  int          n_match, n_kill;
  int          ths [3];

  tca_top uut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .tx_buf_count(tx_buf_count), .tx_frame_whole(tx_frame_whole),
    .tx_collision(tx_collision), .tx_done(tx_done),
    .tx_start(tx_start), .tx_refuse(tx_refuse), .tx_flush(tx_flush),
    .tx_kill(tx_kill), .tx_abandon(tx_abandon), .tx_retry(tx_retry),
    .tx_append_fcs(tx_append_fcs), .tx_pad_60(tx_pad_60),
    .tx_length(tx_length), .cfg_addr_valid(cfg_addr_valid),
    .cfg_addr(cfg_addr), .rx_da(rx_da), .rx_da_valid(rx_da_valid),
    .rx_hashed(rx_hashed), .rx_station_match(rx_station_match),
    .station_address(station_address));

  tca_eng_model eng (
    .clock(clock), .rst(rst), .fill(fill), .whole_in(whole_in),
    .n_coll(n_coll), .tx_start(tx_start), .tx_kill(tx_kill),
    .tx_abandon(tx_abandon), .kill_deaf(kill_deaf),
    .tx_buf_count(tx_buf_count),
    .tx_frame_whole(tx_frame_whole), .tx_collision(tx_collision),
    .tx_done(tx_done));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // pulse counters: one-cycle outputs are never missed by polling
  always @(posedge clock) begin
    if (tx_start) n_start++;
    if (tx_refuse) n_ref++;
    if (tx_flush) n_flush++;
    if (tx_retry) n_retry++;
    if (tx_abandon) n_aband++;
    if (tx_kill) n_kill++;
    if (rx_hashed) n_hash++;
    if (rx_station_match) n_match++;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h",
               $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic clr;
    n_start = 0; n_ref = 0; n_flush = 0; n_retry = 0;
    n_aband = 0; n_hash = 0; n_match = 0; n_kill = 0;
  endtask

  // idle cycle after each access keeps strobes from re-rising in place
  task automatic wr(input logic [9:0] a, input logic [15:0] d,
                    input logic [1:0] be);
    reg_addr  = a;
    reg_wdata = d;
    reg_be    = be;
    reg_wr    = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [9:0] a, input logic [15:0] exp);
    reg_addr = a;
    reg_rd   = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, exp);
    tick(1);
  endtask

  task automatic rx(input logic [47:0] da);
    clr();
    rx_da       = da;
    rx_da_valid = 1'b1;
    tick(1);
    rx_da_valid = 1'b0;
    tick(4);
  endtask

  function automatic logic [15:0] mk(input logic [1:0] sel,
      input logic ab, input logic one, input logic fcs, input logic pad);
    return {2'b00, pad, fcs, 2'b00, one, ab, sel, 6'h09};
  endfunction

  task automatic frame(input logic [15:0] cmd, input logic [15:0] len,
                       input logic [10:0] f, input logic w,
                       input logic [4:0] nc);
    fill     = f;
    whole_in = w;
    n_coll   = nc;
    clr();
    wr(tca_pkg::OFF_CMD, cmd, 2'b11);
    wr(tca_pkg::OFF_LEN, len, 2'b11);
  endtask

  task automatic wait_start(input int lim);
    for (int j = 0; j < lim && n_start == 0; j++)
      tick(1);
    if (n_start == 0) begin
      err_count++;
      close_out();
    end
  endtask

  task automatic drain;
    tick(250);
    fill     = 11'h000;
    whole_in = 1'b0;
    tick(2);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    ths = '{int'(tca_pkg::TH_SEL0), int'(tca_pkg::TH_SEL1),
            int'(tca_pkg::TH_SEL2)};
    err_count = 0; checks_done = 0;
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_be = 2'b00;
    reg_addr = 10'h000; reg_wdata = 16'h0000; fill = 11'h000;
    whole_in = 1'b0; n_coll = 5'h00; cfg_addr_valid = 1'b0;
    kill_deaf = 1'b0;
    cfg_addr = 48'h0; rx_da = 48'h0; rx_da_valid = 1'b0;
    clr();
    tick(8);
    rst = 1'b0;
    for (i = 0; i < 4; i++)
      rd(tca_pkg::OFF_MHF + 10'(2 * i), 16'h0000);
    for (i = 0; i < 4; i++)
      wr(tca_pkg::OFF_MHF + 10'(2 * i), 16'(16'h1357 * (i + 1)), 2'b11);
    for (i = 0; i < 4; i++)
      rd(tca_pkg::OFF_MHF + 10'(2 * i), 16'(16'h1357 * (i + 1)));
    rd(tca_pkg::OFF_CMD, 16'h0000);
    rd(tca_pkg::OFF_LEN, 16'h0000);
    rd(10'h200, 16'h0000);
    wr(tca_pkg::OFF_CMD, 16'h32c0, 2'b11);
    rd(tca_pkg::OFF_TXCFG, 16'h32c9);
    cfg_addr       = 48'h665544332210;
    cfg_addr_valid = 1'b1;
    tick(1);
    cfg_addr_valid = 1'b0;
    tick(2);
    chk(station_address, 48'h665544332210);
    rd(tca_pkg::OFF_STA, 16'h2210);
    rd(tca_pkg::OFF_STA + 10'h004, 16'h6655);
    wr(tca_pkg::OFF_STA + 10'h002, 16'hab77, 2'b01);
    chk(station_address, 48'h665544772210);
    // receive filter: hash hits only on multicast with the bit set
    for (i = 0; i < 4; i++)
      wr(tca_pkg::OFF_MHF + 10'(2 * i), 16'hffff, 2'b11);
    rx(48'h00a0b0c0d001);
    chk(n_hash, 1);
    chk(n_match, 0);
    rx(48'h665544772210);
    chk(n_hash, 0);
    chk(n_match, 1);
    for (i = 0; i < 4; i++)
      wr(tca_pkg::OFF_MHF + 10'(2 * i), 16'h0000, 2'b11);
    rx(48'h00a0b0c0d001);
    chk(n_hash, 0);
    // short length is refused
    frame(mk(2'b00, 0, 0, 0, 0), 16'h0002, 11'd10, 1'b0, 5'h00);
    tick(8);
    chk(n_ref, 1);
    chk(n_start, 0);
    chk(tx_length, 16'h0002);
    drain();
    // thresholds: one byte short holds, the threshold starts; select 11 holds until the whole frame is in
    for (k = 0; k < 3; k++) begin
      frame(mk(2'(k), 0, 0, 0, 0), 16'h05dc, 11'(ths[k] - 1), 1'b0, 5'h00);
      tick(ths[k] + 20);
      chk(n_start, 0);
      fill = 11'(ths[k]);
      wait_start(10);
      chk(n_start, 1);
      drain();
    end
    frame(mk(2'b11, 0, 0, 0, 0), 16'h05dc, 11'd1200, 1'b0, 5'h00);
    tick(1250);
    chk(n_start, 0);
    whole_in = 1'b1;
    wait_start(10);
    chk(n_start, 1);
    drain();
    // crc and padding controls, last case is a 64-byte frame above the pad length
    for (k = 0; k < 5; k++) begin
      frame(mk(2'b00, 0, 0, k[0], k[1]), (k == 4) ? 16'h0040 : 16'h0020,
            11'd8, 1'b0, 5'h00);
      wait_start(40);
      chk(tx_append_fcs, !k[0]);
      chk(tx_pad_60, !k[1] && k < 4);
      drain();
    end
    // collision limits
    for (k = 0; k < 3; k++) begin
      frame(mk(2'b00, 0, k == 0, 0, 0), 16'h0100, 11'd8, 1'b0,
            (k == 0) ? 5'd3 : 5'(14 + k));
      wait_start(40);
      tick(250);
      chk(n_retry, (k == 0) ? 0 : 15);
      chk(n_aband, (k == 1) ? 0 : 1);
      drain();
    end
    // abort while filling: waiting frame dropped
    frame(mk(2'b11, 0, 0, 0, 0), 16'h05dc, 11'd100, 1'b0, 5'h00);
    tick(10);
    wr(tca_pkg::OFF_CMD, mk(2'b11, 1, 0, 0, 0), 2'b11);
    whole_in = 1'b1;
    tick(20);
    chk(n_flush, 1);
    chk(n_start, 0);
    drain();
    // abort while sending: killed within the bound
    frame(mk(2'b00, 0, 0, 0, 0), 16'h05dc, 11'd100, 1'b0, 5'h00);
    wait_start(40);
    tick(3);
    wr(tca_pkg::OFF_CMD, mk(2'b00, 1, 0, 0, 0), 2'b11);
    tick(40);
    chk(n_flush, 1);
    chk(n_kill > 0 && n_kill <= tca_pkg::KILL_CYC, 1'b1);
    chk(tx_kill, 1'b0);
    // engine ignores the stop: the block's own deadline must end it
    drain();
    frame(mk(2'b00, 0, 0, 0, 0), 16'h05dc, 11'd100, 1'b0, 5'h00);
    wait_start(40);
    kill_deaf = 1'b1;
    wr(tca_pkg::OFF_CMD, mk(2'b00, 1, 0, 0, 0), 2'b11);
    tick(1700);
    chk(n_kill, tca_pkg::KILL_CYC);
    chk(tx_kill, 1'b0);
    close_out();
  end
endmodule // tx_command_and_address_filter_test
